// ==== rtl/lsl_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

module lsl_regs #(
  parameter int OTP_DEPTH = lsl_pkg::LSL_OTP_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [7:0] function_mask_i,
  output logic [7:0] lock_state_o,
  input wire logic charger_input_i,
  input wire logic [7:0] multipurpose_pin_i,
  output logic safe_enable_o,
  output logic safe_voltage_select_o,
  output logic [7:0] nvm_addr_o,
  output logic nvm_rd_o,
  input wire logic [7:0] nvm_data_i,
  input wire logic nvm_valid_i,
  output logic otp_ready_o
);
  import lsl_pkg::*;

  // ==========================================================
  // elaboration check
  generate
    if (OTP_DEPTH < 1 || OTP_DEPTH > 256) begin : g_bad_depth
      $error("otp depth must lie between 1 and 256");
    end
  endgenerate

  // ==========================================================
  // types and constants
  typedef enum logic [1:0] {
    BOOT_REQ,
    BOOT_WAIT,
    BOOT_RUN
  } lsl_boot_t;

  typedef struct packed {
    logic [7:0] lock_state;
    logic volt_sel;
    logic [1:0] en_cfg;
    logic [7:0] pin_sel;
    logic [7:0] otp_addr;
    logic [OTP_DEPTH-1:0][7:0] otp_mem;
    lsl_boot_t boot;
    logic [7:0] boot_idx;
    logic nvm_rd;
    logic otp_ready;
    logic [7:0] rdata;
    logic rvalid;
    logic safe_en;
  } lsl_state_t;

  localparam logic [7:0] LAST_IDX = 8'(OTP_DEPTH - 1);
  localparam logic [8:0] DEPTH_W = 9'(OTP_DEPTH);

  // ==========================================================
  // helper functions

  // or of all selected multipurpose pins
  function automatic logic pin_ctrl(input logic [7:0] pins,
                                    input logic [7:0] sel);
    pin_ctrl = |(pins & sel);
  endfunction

  // regulator enable from configuration, charger and pin control
  function automatic logic ldo_on(input logic [1:0] cfg,
                                  input logic chg,
                                  input logic pin);
    logic on;
    on = 1'b0;
    unique case (cfg)
      LSL_EN_OFF: on = 1'b0;
      LSL_EN_CHG: on = chg;
      LSL_EN_CHG_PIN: on = chg & pin;
      LSL_EN_RSVD: on = 1'b0;
    endcase
    ldo_on = on;
  endfunction

  // new lock state after a command write
  function automatic logic [7:0] lock_apply(input logic [7:0] cur,
                                            input logic [7:0] mask,
                                            input logic [7:0] code);
    logic [7:0] res;
    res = cur;
    if (code == LSL_CODE_LOCK) begin
      res = cur | ~mask;
    end else if (code == LSL_CODE_UNLOCK) begin
      res = cur & mask;
    end
    lock_apply = res;
  endfunction

  // ==========================================================
  // state
  lsl_state_t state_reg;
  lsl_state_t state_next;

  // ==========================================================
  // next state logic
  always_comb begin
    state_next = state_reg;
    state_next.nvm_rd = 1'b0;
    state_next.rvalid = 1'b0;

    // boot fill of the otp register file
    unique case (state_reg.boot)
      BOOT_REQ: begin
        state_next.nvm_rd = 1'b1;
        state_next.boot = BOOT_WAIT;
      end
      BOOT_WAIT: begin
        if (nvm_valid_i) begin
          state_next.otp_mem[state_reg.boot_idx] = nvm_data_i;
          if (state_reg.boot_idx == LAST_IDX) begin
            state_next.boot = BOOT_RUN;
            state_next.otp_ready = 1'b1;
          end else begin
            state_next.boot_idx = 8'(state_reg.boot_idx + 8'h01);
            state_next.boot = BOOT_REQ;
          end
        end
      end
      BOOT_RUN: begin
        state_next.otp_ready = 1'b1;
      end
      default: begin
        state_next.boot = BOOT_REQ;
        state_next.boot_idx = 8'h00;
      end
    endcase

    // host register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        LSL_ADDR_LOCK: begin
          state_next.lock_state = lock_apply(state_reg.lock_state,
                                             function_mask_i,
                                             reg_wdata_i);
        end
        LSL_ADDR_SAFE_CTRL: begin
          state_next.volt_sel = reg_wdata_i[LSL_VSEL_BIT];
          state_next.en_cfg = reg_wdata_i[LSL_EN_LSB +: LSL_EN_W];
        end
        LSL_ADDR_PIN_SEL: begin
          state_next.pin_sel = reg_wdata_i;
        end
        LSL_ADDR_OTP_ADDR: begin
          state_next.otp_addr = reg_wdata_i;
        end
        default: begin
          // read only data register and unmapped addresses
          state_next.pin_sel = state_reg.pin_sel;
        end
      endcase
    end

    // host register reads, answered one cycle later
    if (reg_rd_i) begin
      state_next.rvalid = 1'b1;
      unique case (reg_addr_i)
        LSL_ADDR_LOCK: begin
          state_next.rdata = state_reg.lock_state;
        end
        LSL_ADDR_SAFE_CTRL: begin
          state_next.rdata = LSL_RST_DATA;
          state_next.rdata[LSL_VSEL_BIT] = state_reg.volt_sel;
          state_next.rdata[LSL_EN_LSB +: LSL_EN_W] = state_reg.en_cfg;
        end
        LSL_ADDR_PIN_SEL: begin
          state_next.rdata = state_reg.pin_sel;
        end
        LSL_ADDR_OTP_ADDR: begin
          state_next.rdata = state_reg.otp_addr;
        end
        LSL_ADDR_OTP_DATA: begin
          // addresses past the otp depth and an unfinished boot read zero
          if (state_reg.otp_ready &&
              {1'b0, state_reg.otp_addr} < DEPTH_W) begin
            state_next.rdata =
              state_reg.otp_mem[state_reg.otp_addr];
          end else begin
            state_next.rdata = LSL_RST_DATA;
          end
        end
        default: begin
          state_next.rdata = LSL_RST_DATA;
        end
      endcase
    end

    // safe regulator enable
    state_next.safe_en = ldo_on(state_reg.en_cfg, charger_input_i,
                                pin_ctrl(multipurpose_pin_i,
                                         state_reg.pin_sel));
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg.lock_state <= LSL_RST_LOCK;
      state_reg.volt_sel <= LSL_RST_VSEL;
      state_reg.en_cfg <= LSL_RST_EN;
      state_reg.pin_sel <= LSL_RST_PIN_SEL;
      state_reg.otp_addr <= LSL_RST_OTP_ADDR;
      state_reg.otp_mem <= '0;
      state_reg.boot <= BOOT_REQ;
      state_reg.boot_idx <= 8'h00;
      state_reg.nvm_rd <= 1'b0;
      state_reg.otp_ready <= 1'b0;
      state_reg.rdata <= LSL_RST_DATA;
      state_reg.rvalid <= 1'b0;
      state_reg.safe_en <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign reg_rdata_o = state_reg.rdata;
  assign reg_rvalid_o = state_reg.rvalid;
  assign lock_state_o = state_reg.lock_state;
  assign safe_enable_o = state_reg.safe_en;
  assign safe_voltage_select_o = state_reg.volt_sel;
  assign nvm_addr_o = state_reg.boot_idx;
  assign nvm_rd_o = state_reg.nvm_rd;
  assign otp_ready_o = state_reg.otp_ready;

endmodule

`default_nettype wire

// ==== rtl/lsl_pkg.sv ====
// ============================================================
// shared constants of the lock and safe regulator register bank
package lsl_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] LSL_ADDR_LOCK = 8'h84;
  localparam logic [7:0] LSL_ADDR_SAFE_CTRL = 8'h86;
  localparam logic [7:0] LSL_ADDR_PIN_SEL = 8'h87;
  localparam logic [7:0] LSL_ADDR_OTP_ADDR = 8'h88;
  localparam logic [7:0] LSL_ADDR_OTP_DATA = 8'h89;

  // ==========================================================
  // lock command codes
  localparam logic [7:0] LSL_CODE_LOCK = 8'haa;
  localparam logic [7:0] LSL_CODE_UNLOCK = 8'h55;

  // ==========================================================
  // safe control register fields
  localparam int LSL_VSEL_BIT = 7;
  localparam int LSL_EN_LSB = 0;
  localparam int LSL_EN_W = 2;

  // enable configuration codes
  localparam logic [1:0] LSL_EN_OFF = 2'h0;
  localparam logic [1:0] LSL_EN_CHG = 2'h1;
  localparam logic [1:0] LSL_EN_CHG_PIN = 2'h2;
  localparam logic [1:0] LSL_EN_RSVD = 2'h3;

  // ==========================================================
  // function order of lock mask and lock state bits
  localparam int LSL_FN_CHARGER = 0;
  localparam int LSL_FN_BUCK_A = 1;
  localparam int LSL_FN_BUCK_B = 2;
  localparam int LSL_FN_BUCK_C = 3;
  localparam int LSL_FN_BOOST = 4;
  localparam int LSL_FN_BUCKBOOST = 5;
  localparam int LSL_FN_LDO_A = 6;
  localparam int LSL_FN_LDO_B = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] LSL_RST_LOCK = 8'h00;
  localparam logic LSL_RST_VSEL = 1'b0;
  localparam logic [1:0] LSL_RST_EN = 2'h0;
  localparam logic [7:0] LSL_RST_PIN_SEL = 8'h00;
  localparam logic [7:0] LSL_RST_OTP_ADDR = 8'h00;
  localparam logic [7:0] LSL_RST_DATA = 8'h00;

  // ==========================================================
  // otp register file size
  localparam int LSL_OTP_DEPTH = 256;

endpackage

// ==== bench/lsl_regs_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker of the lock and safe regulator bank
module lsl_regs_chk
  import lsl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] function_mask_i,
  input wire logic [7:0] lock_state_o,
  input wire logic charger_input_i,
  input wire logic safe_enable_o,
  input wire logic safe_voltage_select_o,
  input wire logic nvm_rd_o,
  input wire logic otp_ready_o
);
  // decoded write and read strobes
  wire logic wl = reg_wr_i && reg_addr_i == LSL_ADDR_LOCK;
  wire logic rl = reg_rd_i && reg_addr_i == LSL_ADDR_LOCK;
  wire logic rs = reg_rd_i && reg_addr_i == LSL_ADDR_SAFE_CTRL;
  wire logic [7:0] wd = reg_wdata_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_lock_sets: assert property (
    wl && wd == LSL_CODE_LOCK |=>
    lock_state_o == ($past(lock_state_o) | ~$past(function_mask_i)))
    else $error("lock code did not lock unmasked functions");
  a_unlock_clears: assert property (
    wl && wd == LSL_CODE_UNLOCK |=>
    lock_state_o == ($past(lock_state_o) & $past(function_mask_i)))
    else $error("unlock code did not unlock unmasked functions");
  a_lock_idle: assert property (
    !wl || (wd != LSL_CODE_LOCK && wd != LSL_CODE_UNLOCK) |=>
    $stable(lock_state_o)) else $error("lock state moved without code");
  a_masked_kept: assert property (
    wl |=> ((lock_state_o ^ $past(lock_state_o)) &
    $past(function_mask_i)) == 8'h00) else $error("masked bit changed");
  a_lock_readback: assert property (
    rl |=> reg_rdata_o == $past(lock_state_o))
    else $error("lock register read is not lock state");
  a_vsel_follows: assert property (
    reg_wr_i && reg_addr_i == LSL_ADDR_SAFE_CTRL |=>
    safe_voltage_select_o == $past(reg_wdata_i[LSL_VSEL_BIT]))
    else $error("voltage select not taken");
  a_no_charger: assert property (
    !charger_input_i |=> !safe_enable_o)
    else $error("safe regulator on without charger");
  a_rsvd_zero: assert property (
    rs |=> reg_rdata_o[6:2] == 5'h00) else $error("reserved bits set");
  a_otp_dark: assert property (
    !otp_ready_o && reg_rd_i && reg_addr_i == LSL_ADDR_OTP_DATA |=>
    reg_rdata_o == 8'h00) else $error("otp data before boot fill");
  a_fetch_pulse: assert property (
    nvm_rd_o |=> !nvm_rd_o) else $error("boot fetch not one cycle");
endmodule
bind lsl_regs lsl_regs_chk lsl_regs_chk_u (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .function_mask_i(function_mask_i), .lock_state_o(lock_state_o),
  .charger_input_i(charger_input_i), .safe_enable_o(safe_enable_o),
  .safe_voltage_select_o(safe_voltage_select_o), .nvm_rd_o(nvm_rd_o),
  .otp_ready_o(otp_ready_o));
`default_nettype wire

// ==== bench/lsl_regs_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// register level bench of the lock and safe regulator bank
module lsl_regs_tb_top;
  import lsl_pkg::*;
  logic ref_clk_i = 0, resetn_i = 0, wr = 0, rd = 0, chg = 0, nv = 0;
  logic [7:0] addr = 0, wdata = 0, mask = 0, pins = 0, nd = 0;
  logic [7:0] rdata, lock_st, na;
  logic rvalid, sen, vsel, nrd, ready;
  int n_errors = 0, n_compared = 0;
  logic [7:0] mk [7] = '{8'h0f, 8'hf0, 8'h3c, 8'h00, 8'h00, 8'h00, 8'hfe};
  logic [7:0] cd [7] = '{8'haa, 8'haa, 8'h55, 8'h12, 8'hff, 8'h55, 8'haa};
  logic [7:0] ex [7] = '{8'hf0, 8'hff, 8'h3c, 8'h3c, 8'h3c, 8'h00, 8'h01};
  logic [7:0] pt [4] = '{8'h00, 8'h04, 8'h20, 8'hdb};
  always #4 ref_clk_i = ~ref_clk_i;
  lsl_regs #(.OTP_DEPTH(4)) dut_u (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .function_mask_i(mask), .lock_state_o(lock_st),
    .charger_input_i(chg), .multipurpose_pin_i(pins), .safe_enable_o(sen),
    .safe_voltage_select_o(vsel), .nvm_addr_o(na), .nvm_rd_o(nrd),
    .nvm_data_i(nd), .nvm_valid_i(nv), .otp_ready_o(ready));
  // boot store answers a fetch one cycle later, inverse data when idle
  always @(posedge ref_clk_i) begin
    nv <= nrd;
    nd <= nrd ? 8'h5a ^ na : 8'ha5 ^ na;
  end
  // compare one byte and count it
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    // answer stands for one cycle after the taking edge
    @(negedge ref_clk_i);
    chk({7'h0, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  task results;
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #20000;
    n_errors++;
    results();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rreg(LSL_ADDR_OTP_DATA, 8'h00);
    rreg(LSL_ADDR_LOCK, 8'h00);
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk_i);
      mask <= mk[i];
      wreg(LSL_ADDR_LOCK, cd[i]);
      @(negedge ref_clk_i);
      chk(lock_st, ex[i]);
      rreg(LSL_ADDR_LOCK, ex[i]);
    end
    wreg(LSL_ADDR_PIN_SEL, 8'h24);
    rreg(LSL_ADDR_PIN_SEL, 8'h24);
    for (int c = 0; c < 4; c++) begin
      wreg(LSL_ADDR_SAFE_CTRL, {c[0], 5'h1f, c[1:0]});
      rreg(LSL_ADDR_SAFE_CTRL, {c[0], 5'h00, c[1:0]});
      chk({7'h0, vsel}, {7'h0, c[0]});
      for (int k = 0; k < 8; k++) begin
        @(posedge ref_clk_i);
        chg <= k[0];
        pins <= pt[k[2:1]];
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk({7'h0, sen}, {7'h0, k[0] && (c == 1 || c == 2 &&
          |(pt[k[2:1]] & 8'h24))});
      end
    end
    for (int t = 0; t < 50 && ready !== 1'b1; t++) @(negedge ref_clk_i);
    chk({7'h0, ready}, 8'h01);
    for (int a = 0; a < 5; a++) begin
      wreg(LSL_ADDR_OTP_ADDR, a[7:0]);
      rreg(LSL_ADDR_OTP_ADDR, a[7:0]);
      rreg(LSL_ADDR_OTP_DATA, a < 4 ? 8'h5a ^ a[7:0] : 8'h00);
    end
    wreg(LSL_ADDR_OTP_ADDR, 8'h02);
    wreg(LSL_ADDR_OTP_DATA, 8'hff);
    rreg(LSL_ADDR_OTP_DATA, 8'h58);
    rreg(8'h85, 8'h00);
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rreg(LSL_ADDR_LOCK, 8'h00);
    results();
  end
endmodule
`default_nettype wire
